// ---- design/card_descriptor_pkg.sv ----
package card_descriptor_pkg;

    // ------------------------------------------------------------
    // Register port map (byte offsets of 32-bit words)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DESC_W0 = 8'h00;
    localparam logic [7:0] OFS_DESC_W1 = 8'h04;
    localparam logic [7:0] OFS_DESC_W2 = 8'h08;
    localparam logic [7:0] OFS_DESC_W3 = 8'h0C;
    localparam logic [7:0] OFS_CONTROL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // Control register bits
    localparam int CTL_CMD_RESET = 0;
    localparam int CTL_MODE_LSB = 4;
    localparam int CTL_MODE_W = 3;

    // ------------------------------------------------------------
    // Descriptor field positions
    // ------------------------------------------------------------
    localparam int POS_VERSION = 126;
    localparam int POS_ACCESS_TIME = 112;
    localparam int POS_CLOCK_COUNT = 104;
    localparam int POS_RATE = 96;
    localparam int POS_CMD_CLASS = 84;
    localparam int POS_RD_BL_LEN = 80;
    localparam int POS_RD_PARTIAL = 79;
    localparam int POS_WR_MISALIGN = 78;
    localparam int POS_RD_MISALIGN = 77;
    localparam int POS_DRIVER_STAGE = 76;
    localparam int POS_CAPACITY = 48;
    localparam int POS_ERASE_EN = 46;
    localparam int POS_SECTOR_SPAN = 39;
    localparam int POS_GRP_SPAN = 32;
    localparam int POS_GRP_EN = 31;
    localparam int POS_WR_RATIO = 26;
    localparam int POS_WR_BL_LEN = 22;
    localparam int POS_WR_PARTIAL = 21;
    localparam int POS_LAYOUT_GRP = 15;
    localparam int POS_COPY = 14;
    localparam int POS_PERM_LOCK = 13;
    localparam int POS_TEMP_LOCK = 12;
    localparam int POS_LAYOUT = 10;
    localparam int POS_PC_LOCK = 9;
    localparam int POS_CHECK = 1;
    localparam int POS_ONE = 0;

    // ------------------------------------------------------------
    // Fixed field values
    // ------------------------------------------------------------
    localparam logic [1:0] VAL_VERSION = 2'h1;
    localparam logic [7:0] VAL_ACCESS_TIME = 8'h0E;
    localparam logic [7:0] VAL_CLOCK_COUNT = 8'h00;
    localparam logic [3:0] VAL_BL_LEN = 4'h9;
    localparam logic VAL_ERASE_EN = 1'b1;
    localparam logic [6:0] VAL_SECTOR_SPAN = 7'h7F;
    localparam logic [6:0] VAL_GRP_SPAN = 7'h00;
    localparam logic [2:0] VAL_WR_RATIO = 3'h2;

    localparam logic [7:0] RATE_DEFAULT = 8'h32;
    localparam logic [7:0] RATE_HIGH = 8'h5A;
    localparam logic [7:0] RATE_50 = 8'h0B;
    localparam logic [7:0] RATE_104 = 8'h2B;

    // File layout codes for group 0
    typedef enum logic [1:0] {
        LAYOUT_PARTITIONED = 2'h0,
        LAYOUT_BOOT_SECTOR = 2'h1,
        LAYOUT_UNIVERSAL = 2'h2,
        LAYOUT_OTHER = 2'h3
    } file_layout_t;

    // Bus speed modes
    typedef enum logic [2:0] {
        MODE_DEFAULT = 3'h0,
        MODE_HIGH = 3'h1,
        MODE_SE50 = 3'h2,
        MODE_DE50 = 3'h3,
        MODE_SE104 = 3'h4
    } bus_mode_t;

    // Writable descriptor state
    typedef struct packed {
        logic copy;
        logic perm_lock;
        logic temp_lock;
        logic pc_lock;
        logic [1:0] layout;
        logic [6:0] check;
        logic [7:0] rate;
    } desc_state_t;

endpackage

// ---- design/card_descriptor.sv ----
`timescale 1ns/1ps
module card_descriptor
    import card_descriptor_pkg::*;
#(
    parameter logic [11:0] CMD_CLASSES = 12'h5B5,
    parameter logic DRIVER_STAGE = 1'b0,
    parameter logic [21:0] USER_CAPACITY = 22'h001010,
    parameter logic [1:0] INIT_LAYOUT = 2'h0,
    parameter logic [6:0] INIT_CHECK = 7'h00,
    parameter logic ROM_CARD = 1'b0
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic LOCK_SUPPORTED,
    output logic WRITE_BLOCKED
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    desc_state_t st_r, st_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic supp_m_r, supp_r;
    logic blocked_r, blocked_nxt;
    logic [127:0] desc;
    logic [127:0] wmask;

    // ------------------------------------------------------------
    // Descriptor assembly
    // ------------------------------------------------------------
    always_comb begin
        desc = '0;
        desc[POS_VERSION +: 2] = VAL_VERSION;
        desc[POS_ACCESS_TIME +: 8] = VAL_ACCESS_TIME;
        desc[POS_CLOCK_COUNT +: 8] = VAL_CLOCK_COUNT;
        desc[POS_RATE +: 8] = st_r.rate;
        desc[POS_CMD_CLASS +: 12] = CMD_CLASSES;
        desc[POS_RD_BL_LEN +: 4] = VAL_BL_LEN;
        desc[POS_RD_PARTIAL] = 1'b0;
        desc[POS_WR_MISALIGN] = 1'b0;
        desc[POS_RD_MISALIGN] = 1'b0;
        desc[POS_DRIVER_STAGE] = DRIVER_STAGE;
        desc[POS_CAPACITY +: 22] = USER_CAPACITY;
        desc[POS_ERASE_EN] = VAL_ERASE_EN;
        desc[POS_SECTOR_SPAN +: 7] = VAL_SECTOR_SPAN;
        desc[POS_GRP_SPAN +: 7] = VAL_GRP_SPAN;
        desc[POS_GRP_EN] = 1'b0;
        desc[POS_WR_RATIO +: 3] = VAL_WR_RATIO;
        desc[POS_WR_BL_LEN +: 4] = VAL_BL_LEN;
        desc[POS_WR_PARTIAL] = 1'b0;
        desc[POS_LAYOUT_GRP] = 1'b0;
        desc[POS_COPY] = st_r.copy;
        desc[POS_PERM_LOCK] = st_r.perm_lock;
        desc[POS_TEMP_LOCK] = st_r.temp_lock;
        desc[POS_LAYOUT +: 2] = st_r.layout;
        desc[POS_PC_LOCK] = st_r.pc_lock & supp_r;
        desc[POS_CHECK +: 7] = st_r.check;
        desc[POS_ONE] = 1'b1;
    end

    // Write-once bits accept only a set
    always_comb begin
        wmask = '0;
        wmask[POS_COPY] = ~st_r.copy & ~ROM_CARD;
        wmask[POS_PERM_LOCK] = ~st_r.perm_lock;
        wmask[POS_TEMP_LOCK] = 1'b1;
        wmask[POS_LAYOUT +: 2] = {2{~ROM_CARD}};
        wmask[POS_PC_LOCK] = supp_r;
        wmask[POS_CHECK +: 7] = 7'h7F;
    end

    // ------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------
    always_comb begin
        logic [127:0] wfull;
        logic [1:0] widx;
        logic [2:0] mode;
        wfull = desc;
        widx = ADDR[3:2];
        mode = WDATA[CTL_MODE_LSB +: CTL_MODE_W];
        st_nxt = st_r;
        rdata_nxt = '0;
        // Lock bit counts only while support is seen, as it reads
        blocked_nxt = (st_r.pc_lock & supp_r) | st_r.perm_lock | st_r.temp_lock;
        if (WR && ADDR < OFS_CONTROL && ADDR[1:0] == 2'h0) begin
            wfull[widx*32 +: 32] = WDATA;
            wfull = (wfull & wmask) | (desc & ~wmask);
            st_nxt.copy = wfull[POS_COPY];
            st_nxt.perm_lock = wfull[POS_PERM_LOCK];
            st_nxt.temp_lock = wfull[POS_TEMP_LOCK];
            st_nxt.layout = wfull[POS_LAYOUT +: 2];
            st_nxt.pc_lock = wfull[POS_PC_LOCK] & supp_r;
            st_nxt.check = wfull[POS_CHECK +: 7];
        end
        if (WR && ADDR == OFS_CONTROL) begin
            if (WDATA[CTL_CMD_RESET]) begin
                st_nxt.rate = RATE_DEFAULT;
            end else begin
                case (mode)
                    MODE_DEFAULT: st_nxt.rate = RATE_DEFAULT;
                    MODE_HIGH: st_nxt.rate = RATE_HIGH;
                    MODE_SE50: st_nxt.rate = RATE_50;
                    MODE_DE50: st_nxt.rate = RATE_50;
                    MODE_SE104: st_nxt.rate = RATE_104;
                    default: st_nxt.rate = st_r.rate;
                endcase
            end
        end
        if (!supp_r) begin
            st_nxt.pc_lock = 1'b0;
        end
        if (RD) begin
            case (ADDR)
                OFS_DESC_W0: rdata_nxt = desc[31:0];
                OFS_DESC_W1: rdata_nxt = desc[63:32];
                OFS_DESC_W2: rdata_nxt = desc[95:64];
                OFS_DESC_W3: rdata_nxt = desc[127:96];
                OFS_CONTROL: rdata_nxt = {24'h0, st_r.rate};
                OFS_STATUS: rdata_nxt = {30'h0, supp_r, WRITE_BLOCKED};
                default: rdata_nxt = '0;
            endcase
        end
    end

    // RST stands for power cycle
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            // Check field starts as the INIT_CHECK parameter; no checksum is computed
            st_r <= '{copy: 1'b0, perm_lock: 1'b0, temp_lock: 1'b0,
                      pc_lock: 1'b0, layout: INIT_LAYOUT, check: INIT_CHECK,
                      rate: RATE_DEFAULT};
            rdata_r <= '0;
            blocked_r <= 1'b0;
            supp_m_r <= 1'b0;
            supp_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            rdata_r <= rdata_nxt;
            blocked_r <= blocked_nxt;
            supp_m_r <= LOCK_SUPPORTED;
            supp_r <= supp_m_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign RDATA = rdata_r;
    assign WRITE_BLOCKED = blocked_r;

endmodule // card_descriptor

// ---- bench/card_descriptor_assertions.sv ----
`timescale 1ns/1ps
module card_descriptor_assertions
    import card_descriptor_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic LOCK_SUPPORTED,
    input wire logic WRITE_BLOCKED
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence rd_at(logic [7:0] a);
        RD && ADDR == a;
    endsequence
    sequence mode_set(logic [2:0] m);
        WR && ADDR == OFS_CONTROL && !WDATA[0] && WDATA[6:4] == m ##2 rd_at(OFS_DESC_W3);
    endsequence
    rdata_idle_a: assert property (!RD |=> RDATA == 32'h0)
        else $error("read data not idle");
    word3_fixed_a: assert property (rd_at(OFS_DESC_W3) |=> RDATA[31:8] == 24'h400E00)
        else $error("top word fixed fields wrong");
    rate_legal_a: assert property (rd_at(OFS_DESC_W3) |=> RDATA[7:0] inside {8'h32, 8'h5A, 8'h0B, 8'h2B})
        else $error("rate code illegal");
    rate_50_a: assert property (mode_set(MODE_SE50) or mode_set(MODE_DE50) |=> RDATA[7:0] == 8'h0B)
        else $error("rate not 0B in 50 MHz modes");
    rate_104_a: assert property (mode_set(MODE_SE104) |=> RDATA[7:0] == 8'h2B)
        else $error("rate not 2B in 104 MHz mode");
    rate_reset_a: assert property (WR && ADDR == OFS_CONTROL && WDATA[0] ##2 rd_at(OFS_DESC_W3)
        |=> RDATA[7:0] == 8'h32) else $error("rate not 32 after reset command");
    word2_fixed_a: assert property (rd_at(OFS_DESC_W2) |=> RDATA[19:15] == 5'h12 && RDATA[11:6] == 6'h00)
        else $error("word 2 fixed fields wrong");
    word1_fixed_a: assert property (rd_at(OFS_DESC_W1) |=> RDATA[15:0] == 16'h7F80)
        else $error("word 1 fixed fields wrong");
    word0_fixed_a: assert property (rd_at(OFS_DESC_W0) |=> RDATA[31:15] == 17'h01480 && !RDATA[8] && RDATA[0])
        else $error("word 0 fixed fields wrong");
    blocked_a: assert property (rd_at(OFS_DESC_W0) |=> WRITE_BLOCKED == (RDATA[9] | RDATA[12] | RDATA[13]))
        else $error("write block flag disagrees with locks");
    no_support_a: assert property ((!LOCK_SUPPORTED)[*4] ##0 rd_at(OFS_DESC_W0) |=> !RDATA[9])
        else $error("lock bit set without support");
endmodule // card_descriptor_assertions

// ---- bench/host_model.sv ----
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    input wire logic [31:0] rdata,
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // Check bits come from the caller and are written as given
    task automatic wr_word(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~v;
    endtask
    task automatic rd_word(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        v = rdata;
    endtask
endmodule // host_model

// ---- bench/card_descriptor_tb.sv ----
`timescale 1ns/1ps
module card_descriptor_tb;
    import card_descriptor_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic lock_sup = 1'b1;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic [31:0] rom_rdata;
    logic blocked;
    logic [31:0] d;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    localparam logic [31:0] W0 = 32'h0A400001;
    always #5 clk = ~clk;
    card_descriptor dut_u (.SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .LOCK_SUPPORTED(lock_sup), .WRITE_BLOCKED(blocked));
    card_descriptor #(.ROM_CARD(1'b1)) dut_rom_u (.SYS_CLK(clk), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rom_rdata), .LOCK_SUPPORTED(lock_sup),
        .WRITE_BLOCKED());
    host_model host_u (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        host_u.rd_word(a, d);
        check(d, exp);
    endtask
    task automatic do_reset(input logic sup);
        @(posedge clk);
        rst <= 1'b1;
        lock_sup <= sup;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_fixed();
        for (int w = 1; w < 4; w++) host_u.wr_word(8'(w * 4), 32'hFFFFFFFF);
        rdc(OFS_DESC_W3, 32'h400E0032);
        rdc(OFS_DESC_W2, 32'h5B590000);
        rdc(OFS_DESC_W1, 32'h10107F80);
        rdc(OFS_DESC_W0, W0);
        rdc(8'h40, 32'h0);
        $display("fixed fields done");
    endtask
    task automatic t_rates();
        logic [7:0] r [5] = '{8'h32, 8'h5A, 8'h0B, 8'h0B, 8'h2B};
        for (int m = 0; m < 5; m++) begin
            host_u.wr_word(OFS_CONTROL, 32'(m) << 4);
            rdc(OFS_DESC_W3, {24'h400E00, r[m]});
        end
        host_u.wr_word(OFS_CONTROL, 32'h1);
        rdc(OFS_DESC_W3, 32'h400E0032);
        $display("rates done");
    endtask
    task automatic t_locks();
        host_u.wr_word(OFS_DESC_W0, 32'h2AA);
        rdc(OFS_DESC_W0, W0 | 32'h2AA);
        check({31'h0, blocked}, 32'h1);
        host_u.wr_word(OFS_DESC_W0, 32'h0);
        rdc(OFS_DESC_W0, W0);
        for (int l = 0; l < 4; l++) begin
            host_u.wr_word(OFS_DESC_W0, 32'h1000 | 32'(l) << 10);
            rdc(OFS_DESC_W0, W0 | 32'h1000 | 32'(l) << 10);
            check(rom_rdata, W0 | 32'h1000);
        end
        host_u.wr_word(OFS_DESC_W0, 32'hFFFFFFFF);
        rdc(OFS_DESC_W0, 32'h0A407EFF);
        check(rom_rdata & 32'h00000C00, 32'h0);
        host_u.wr_word(OFS_DESC_W0, 32'h0);
        rdc(OFS_DESC_W0, 32'h0A406001);
        check({31'h0, blocked}, 32'h1);
        $display("locks done");
    endtask
    task automatic t_power();
        do_reset(1'b0);
        host_u.wr_word(OFS_DESC_W0, 32'h200);
        rdc(OFS_DESC_W0, W0);
        rdc(OFS_STATUS, 32'h0);
        @(posedge clk);
        lock_sup <= 1'b1;
        repeat (4) @(posedge clk);
        host_u.wr_word(OFS_DESC_W0, 32'h200);
        rdc(OFS_STATUS, 32'h3);
        do_reset(1'b1);
        rdc(OFS_DESC_W0, W0);
        check({31'h0, blocked}, 32'h0);
        $display("power cycle done");
    endtask
    initial begin
        do_reset(1'b1);
        t_fixed();
        t_rates();
        t_locks();
        t_power();
        tally_and_finish();
    end
endmodule // card_descriptor_tb
bind card_descriptor card_descriptor_assertions chk_u (.SYS_CLK(SYS_CLK), .RST(RST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .LOCK_SUPPORTED(LOCK_SUPPORTED), .WRITE_BLOCKED(WRITE_BLOCKED));
